// ---- verilog/hvmr_pkg.sv ----
`default_nettype none
package hvmr_pkg;

   // Operating mode as decoded by the mode controller.
   typedef enum logic [2:0] {
      HVMR_MODE_INIT     = 3'h0,
      HVMR_MODE_NORMAL   = 3'h1,
      HVMR_MODE_STOP     = 3'h2,
      HVMR_MODE_SLEEP    = 3'h3,
      HVMR_MODE_RESTART  = 3'h4,
      HVMR_MODE_FAILSAFE = 3'h5
   } hvmr_mode_type;

   // Setting selected by a configuration write.
   typedef enum logic [2:0] {
      HVMR_SEL_MEAS   = 3'h0,
      HVMR_SEL_GPIO   = 3'h1,
      HVMR_SEL_PULL   = 3'h2,
      HVMR_SEL_WAKE   = 3'h3,
      HVMR_SEL_FOTEST = 3'h4
   } hvmr_sel_type;

   localparam int HVMR_DATA_W = 8;
   localparam int HVMR_GPIO_W = 3;
   localparam int HVMR_PULL_W = 4;
   localparam int HVMR_WAKE_W = 1;
   localparam int HVMR_NCHAN  = 2;

   // Multi-function pin configurations.
   localparam logic [2:0] HVMR_GPIO_OFF  = 3'h0;
   localparam logic [2:0] HVMR_GPIO_FAIL = 3'h1;
   localparam logic [2:0] HVMR_GPIO_WAKE = 3'h2;
   localparam logic [2:0] HVMR_GPIO_LS   = 3'h3;
   localparam logic [2:0] HVMR_GPIO_HS   = 3'h4;

   // Field positions.
   localparam int HVMR_BIT_MEAS      = 0;
   localparam int HVMR_BIT_FOTEST    = 0;
   localparam int HVMR_BIT_WAKE_EN   = 0;
   localparam int HVMR_BIT_SENSE_PU  = 0;
   localparam int HVMR_BIT_SENSE_PD  = 1;
   localparam int HVMR_BIT_MULTI_PU  = 2;
   localparam int HVMR_BIT_MULTI_PD  = 3;
   localparam int HVMR_CH_SENSE      = 0;
   localparam int HVMR_CH_MULTI      = 1;

   // Reset values.
   localparam logic [2:0] HVMR_GPIO_RST = 3'h0;
   localparam logic [3:0] HVMR_PULL_RST = 4'h0;
   localparam logic       HVMR_WAKE_RST = 1'b0;

endpackage
`default_nettype wire

// ---- verilog/hvmr_wake_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
module hvmr_wake_chan (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic resetn,
   // Control.
   input  wire logic update_en,
   input  wire logic wake_en,
   input  wire logic clr,
   // Pin level.
   input  wire logic pin_level,
   // Status.
   output logic      level_stat,
   output logic      wake_flag
);

   logic prev_level;
   logic next_prev_level;
   logic next_level_stat;
   logic next_wake_flag;

   always_comb begin
      next_prev_level = prev_level;
      next_level_stat = level_stat;
      next_wake_flag  = wake_flag;
      if (clr) begin
         next_wake_flag = 1'b0;
      end
      if (update_en) begin
         next_prev_level = pin_level;
         next_level_stat = pin_level;
         // A wake edge in the clearing cycle still sets the flag.
         if (wake_en && pin_level && !prev_level) begin
            next_wake_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_level <= 1'b0;
         level_stat <= 1'b0;
         wake_flag  <= 1'b0;
      end else begin
         prev_level <= next_prev_level;
         level_stat <= next_level_stat;
         wake_flag  <= next_wake_flag;
      end
   end

endmodule
`default_nettype wire

// ---- verilog/hvmr_ctrl.sv ----
// Summary of operation
// - After reset measurement is off, switch open, pins keep ordinary functions.
// - Switch closes only in Normal mode while measurement enable is set.
// - Measurement enable setting is kept through all mode changes.
// - Measurement enabled turns off pull currents on both pins.
// - Measurement enabled gates both pins' internal input signals.
// - Pull, wake and GPIO settings are still stored; pull and wake are ignored, but a GPIO fail output setting opens the switch.
// - Wake and level status do not update while measuring.
// - Sleep while measuring with only pin wake sources flags error and enters Restart.
// - Wake enable bits stay writable but are ignored while measuring.
// - No fail output, force test, GPIO or pin wake while measuring.
// - GPIO configuration change attempts while measuring flag an error.
// - Enable refused with error unless the multi pin is configured off.
// - Fail-Safe with measurement on keeps configuration, switch open.
// - Fail-Safe with measurement off makes the sense pin a wake source.
// - Active path routes sense voltage out unless pin is fail output.
`timescale 1ns/1ps
`default_nettype none
module hvmr_ctrl
   import hvmr_pkg::*;
(
   // Clock and reset.
   input  wire logic                   CLK_SYS,
   input  wire logic                   RESETN,
   // Operating mode from the mode controller.
   input  wire logic [2:0]             MODE,
   // Configuration write port.
   input  wire logic                   CFG_WR,
   input  wire logic [2:0]             CFG_SEL,
   input  wire logic [HVMR_DATA_W-1:0] CFG_WDATA,
   // Mode requests and other wake sources.
   input  wire logic                   SLEEP_REQ,
   input  wire logic                   OTHER_WAKE_EN,
   // Pin levels and device fail condition.
   input  wire logic                   SENSE_IN,
   input  wire logic                   MULTI_IN,
   input  wire logic                   FAIL_ASSERT,
   // Wake status clear strobes.
   input  wire logic                   CLR_WAKE_ZERO,
   input  wire logic                   CLR_WAKE_ONE,
   // Analog switch and pull current controls.
   output logic                        MEAS_SWITCH_CLOSE,
   output logic                        SENSE_PULL_UP_EN,
   output logic                        SENSE_PULL_DN_EN,
   output logic                        MULTI_PULL_UP_EN,
   output logic                        MULTI_PULL_DN_EN,
   // Multi pin drivers.
   output logic                        FAIL_OUT_DRIVE,
   output logic                        GPIO_LS_ON,
   output logic                        GPIO_HS_ON,
   // Gated internal pin signals.
   output logic                        SENSE_INT,
   output logic                        MULTI_INT,
   // Wake sources and status.
   output logic                        SENSE_WAKE_ACTIVE,
   output logic                        MULTI_WAKE_ACTIVE,
   output logic                        WAKE_STATUS_ZERO,
   output logic                        WAKE_STATUS_ONE,
   output logic [1:0]                  WAKE_LEVEL_STATUS,
   // Error and mode transition pulses.
   output logic                        SPI_FAIL_SET,
   output logic                        RESTART_REQ,
   output logic                        SLEEP_GRANT,
   // Stored settings readback.
   output logic                        MEAS_PATH_ENABLE,
   output logic [HVMR_GPIO_W-1:0]      GPIO_CONFIG,
   output logic [HVMR_PULL_W-1:0]      SENSE_PULL_CONFIG,
   output logic                        WAKE_CONTROL_ONE,
   output logic                        FAILOUT_FORCE_TEST
);

////////////////////////////////////////////////////////////////////////////////

   logic                   meas_path_enable;
   logic [HVMR_GPIO_W-1:0] gpio_config;
   logic [HVMR_PULL_W-1:0] sense_pull_config;
   logic                   wake_control_one;
   logic                   failout_force_test;

   logic                   next_meas_path_enable;
   logic [HVMR_GPIO_W-1:0] next_gpio_config;
   logic [HVMR_PULL_W-1:0] next_sense_pull_config;
   logic                   next_wake_control_one;
   logic                   next_failout_force_test;
   logic                   next_spi_fail;
   logic                   next_restart_req;
   logic                   next_sleep_grant;

   logic                   is_normal;
   logic                   is_failsafe;
   logic                   wr_meas;
   logic                   wr_gpio;

   assign is_normal   = (MODE == HVMR_MODE_NORMAL);
   assign is_failsafe = (MODE == HVMR_MODE_FAILSAFE);
   assign wr_meas     = CFG_WR && (CFG_SEL == HVMR_SEL_MEAS);
   assign wr_gpio     = CFG_WR && (CFG_SEL == HVMR_SEL_GPIO);

////////////////////////////////////////////////////////////////////////////////
// Stored settings and error handling.

   always_comb begin
      next_meas_path_enable   = meas_path_enable;
      next_gpio_config        = gpio_config;
      next_sense_pull_config  = sense_pull_config;
      next_wake_control_one   = wake_control_one;
      next_failout_force_test = failout_force_test;
      next_spi_fail           = 1'b0;
      next_restart_req        = 1'b0;
      next_sleep_grant        = 1'b0;

      if (wr_meas) begin
         if (CFG_WDATA[HVMR_BIT_MEAS] && (gpio_config != HVMR_GPIO_OFF)) begin
            next_spi_fail = 1'b1;
         end else begin
            next_meas_path_enable = CFG_WDATA[HVMR_BIT_MEAS];
         end
      end

      if (wr_gpio) begin
         next_gpio_config = CFG_WDATA[HVMR_GPIO_W-1:0];
         if (meas_path_enable && (CFG_WDATA[HVMR_GPIO_W-1:0] != gpio_config)) begin
            next_spi_fail = 1'b1;
         end
      end

      if (CFG_WR && (CFG_SEL == HVMR_SEL_PULL)) begin
         next_sense_pull_config = CFG_WDATA[HVMR_PULL_W-1:0];
      end

      if (CFG_WR && (CFG_SEL == HVMR_SEL_WAKE)) begin
         next_wake_control_one = CFG_WDATA[HVMR_BIT_WAKE_EN];
      end

      if (CFG_WR && (CFG_SEL == HVMR_SEL_FOTEST)) begin
         next_failout_force_test = CFG_WDATA[HVMR_BIT_FOTEST];
      end

      if (SLEEP_REQ) begin
         if (meas_path_enable && !OTHER_WAKE_EN &&
             (wake_control_one || (gpio_config == HVMR_GPIO_WAKE))) begin
            next_spi_fail    = 1'b1;
            next_restart_req = 1'b1;
         end else begin
            next_sleep_grant = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         meas_path_enable   <= 1'b0;
         gpio_config        <= HVMR_GPIO_RST;
         sense_pull_config  <= HVMR_PULL_RST;
         wake_control_one   <= HVMR_WAKE_RST;
         failout_force_test <= 1'b0;
         SPI_FAIL_SET       <= 1'b0;
         RESTART_REQ        <= 1'b0;
         SLEEP_GRANT        <= 1'b0;
      end else begin
         meas_path_enable   <= next_meas_path_enable;
         gpio_config        <= next_gpio_config;
         sense_pull_config  <= next_sense_pull_config;
         wake_control_one   <= next_wake_control_one;
         failout_force_test <= next_failout_force_test;
         SPI_FAIL_SET       <= next_spi_fail;
         RESTART_REQ        <= next_restart_req;
         SLEEP_GRANT        <= next_sleep_grant;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Pin function steering.  Outputs are computed from the next setting so that
// the switch follows the enable write without an extra cycle of lag.

   logic       next_switch;
   logic [3:0] next_pull;
   logic       next_fail_drive;
   logic       next_ls_on;
   logic       next_hs_on;
   logic       next_sense_int;
   logic       next_multi_int;
   logic       next_sense_wake;
   logic       next_multi_wake;

   always_comb begin
      next_switch = next_meas_path_enable && is_normal &&
                    (next_gpio_config != HVMR_GPIO_FAIL);

      next_pull = next_meas_path_enable ? 4'h0 : next_sense_pull_config;

      next_fail_drive = !next_meas_path_enable &&
                        (next_gpio_config == HVMR_GPIO_FAIL) &&
                        (FAIL_ASSERT || next_failout_force_test || is_failsafe);
      next_ls_on      = !next_meas_path_enable && (next_gpio_config == HVMR_GPIO_LS);
      next_hs_on      = !next_meas_path_enable && (next_gpio_config == HVMR_GPIO_HS);

      next_sense_int = next_meas_path_enable ? 1'b0 : SENSE_IN;
      next_multi_int = next_meas_path_enable ? 1'b0 : MULTI_IN;

      next_sense_wake = !next_meas_path_enable && (next_wake_control_one || is_failsafe);
      next_multi_wake = !next_meas_path_enable && (next_gpio_config == HVMR_GPIO_WAKE);
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         MEAS_SWITCH_CLOSE <= 1'b0;
         SENSE_PULL_UP_EN  <= 1'b0;
         SENSE_PULL_DN_EN  <= 1'b0;
         MULTI_PULL_UP_EN  <= 1'b0;
         MULTI_PULL_DN_EN  <= 1'b0;
         FAIL_OUT_DRIVE    <= 1'b0;
         GPIO_LS_ON        <= 1'b0;
         GPIO_HS_ON        <= 1'b0;
         SENSE_INT         <= 1'b0;
         MULTI_INT         <= 1'b0;
         SENSE_WAKE_ACTIVE <= 1'b0;
         MULTI_WAKE_ACTIVE <= 1'b0;
      end else begin
         MEAS_SWITCH_CLOSE <= next_switch;
         SENSE_PULL_UP_EN  <= next_pull[HVMR_BIT_SENSE_PU];
         SENSE_PULL_DN_EN  <= next_pull[HVMR_BIT_SENSE_PD];
         MULTI_PULL_UP_EN  <= next_pull[HVMR_BIT_MULTI_PU];
         MULTI_PULL_DN_EN  <= next_pull[HVMR_BIT_MULTI_PD];
         FAIL_OUT_DRIVE    <= next_fail_drive;
         GPIO_LS_ON        <= next_ls_on;
         GPIO_HS_ON        <= next_hs_on;
         SENSE_INT         <= next_sense_int;
         MULTI_INT         <= next_multi_int;
         SENSE_WAKE_ACTIVE <= next_sense_wake;
         MULTI_WAKE_ACTIVE <= next_multi_wake;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Wake status, one channel per pin.

   logic [HVMR_NCHAN-1:0] chan_update;
   logic [HVMR_NCHAN-1:0] chan_wake_en;
   logic [HVMR_NCHAN-1:0] chan_clr;
   logic [HVMR_NCHAN-1:0] chan_level;
   logic [HVMR_NCHAN-1:0] chan_lvl_stat;
   logic [HVMR_NCHAN-1:0] chan_flag;

   assign chan_update = meas_path_enable ? 2'h0 : 2'h3;

   assign chan_wake_en[HVMR_CH_SENSE] = wake_control_one || is_failsafe;
   assign chan_wake_en[HVMR_CH_MULTI] = (gpio_config == HVMR_GPIO_WAKE);
   assign chan_clr[HVMR_CH_SENSE]     = CLR_WAKE_ZERO;
   assign chan_clr[HVMR_CH_MULTI]     = CLR_WAKE_ONE;
   assign chan_level[HVMR_CH_SENSE]   = SENSE_IN;
   assign chan_level[HVMR_CH_MULTI]   = MULTI_IN;

   genvar gi;
   generate
      for (gi = 0; gi < HVMR_NCHAN; gi = gi + 1) begin : g_chan
         hvmr_wake_chan u_chan (
            .clk        (CLK_SYS),
            .resetn     (RESETN),
            .update_en  (chan_update[gi]),
            .wake_en    (chan_wake_en[gi]),
            .clr        (chan_clr[gi]),
            .pin_level  (chan_level[gi]),
            .level_stat (chan_lvl_stat[gi]),
            .wake_flag  (chan_flag[gi])
         );
      end
   endgenerate

   assign WAKE_STATUS_ZERO  = chan_flag[HVMR_CH_SENSE];
   assign WAKE_STATUS_ONE   = chan_flag[HVMR_CH_MULTI];
   assign WAKE_LEVEL_STATUS = chan_lvl_stat;

////////////////////////////////////////////////////////////////////////////////
// Stored settings readback straight from their registers.

   assign MEAS_PATH_ENABLE   = meas_path_enable;
   assign GPIO_CONFIG        = gpio_config;
   assign SENSE_PULL_CONFIG  = sense_pull_config;
   assign WAKE_CONTROL_ONE   = wake_control_one;
   assign FAILOUT_FORCE_TEST = failout_force_test;

endmodule
`default_nettype wire

// ---- testbench/hvmr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hvmr_host_model
   import hvmr_pkg::*;
(
   // Clock.
   input  wire logic                   clk,
   // Requests from the bench.
   input  wire logic                   req,
   input  wire logic [2:0]             req_sel,
   input  wire logic [HVMR_DATA_W-1:0] req_data,
   // Configuration port of the device.
   output logic                        cfg_wr,
   output logic [2:0]                  cfg_sel,
   output logic [HVMR_DATA_W-1:0]      cfg_wdata
);
   // Idle lines show the inverse so the device cannot lean on a stale value.
   always @(posedge clk) begin
      cfg_wr <= req;
      cfg_sel <= req ? req_sel : ~req_sel;
      cfg_wdata <= req ? req_data : ~req_data;
   end
endmodule
`default_nettype wire

// ---- testbench/hvmr_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module hvmr_ctrl_checker
   import hvmr_pkg::*;
(
   // Clock, reset and stimulus.
   input wire logic                   CLK_SYS,
   input wire logic                   RESETN,
   input wire logic [2:0]             MODE,
   input wire logic                   CFG_WR,
   input wire logic [2:0]             CFG_SEL,
   input wire logic [HVMR_DATA_W-1:0] CFG_WDATA,
   input wire logic                   SLEEP_REQ,
   input wire logic                   OTHER_WAKE_EN,
   // Design outputs.
   input wire logic                   MEAS_SWITCH_CLOSE,
   input wire logic                   SENSE_PULL_UP_EN,
   input wire logic                   SENSE_PULL_DN_EN,
   input wire logic                   MULTI_PULL_UP_EN,
   input wire logic                   MULTI_PULL_DN_EN,
   input wire logic                   FAIL_OUT_DRIVE,
   input wire logic                   GPIO_LS_ON,
   input wire logic                   GPIO_HS_ON,
   input wire logic                   SENSE_INT,
   input wire logic                   MULTI_INT,
   input wire logic                   SENSE_WAKE_ACTIVE,
   input wire logic                   MULTI_WAKE_ACTIVE,
   input wire logic [1:0]             WAKE_LEVEL_STATUS,
   input wire logic                   SPI_FAIL_SET,
   input wire logic                   RESTART_REQ,
   input wire logic                   SLEEP_GRANT,
   input wire logic                   MEAS_PATH_ENABLE,
   input wire logic [HVMR_GPIO_W-1:0] GPIO_CONFIG,
   input wire logic                   WAKE_CONTROL_ONE
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);

   AST_SWITCH: assert property (MEAS_SWITCH_CLOSE == (MEAS_PATH_ENABLE && $past(MODE) == 3'h1
      && GPIO_CONFIG != 3'h1)) else $error("switch differs from enable and mode");
   AST_PULL_OFF: assert property (MEAS_PATH_ENABLE |-> !(SENSE_PULL_UP_EN || SENSE_PULL_DN_EN
      || MULTI_PULL_UP_EN || MULTI_PULL_DN_EN)) else $error("pull on while measuring");
   AST_GATED: assert property (MEAS_PATH_ENABLE |-> !(SENSE_INT || MULTI_INT
      || SENSE_WAKE_ACTIVE || MULTI_WAKE_ACTIVE)) else $error("pin signal live while measuring");
   AST_NO_DRIVE: assert property (MEAS_PATH_ENABLE |-> !(FAIL_OUT_DRIVE || GPIO_LS_ON
      || GPIO_HS_ON)) else $error("pin driven while measuring");
   AST_FROZEN: assert property (MEAS_PATH_ENABLE && $past(MEAS_PATH_ENABLE)
      |-> $stable(WAKE_LEVEL_STATUS)) else $error("level status moved while measuring");
   AST_REFUSE: assert property (CFG_WR && CFG_SEL == 3'h0 && CFG_WDATA[0] && GPIO_CONFIG != 3'h0
      && !MEAS_PATH_ENABLE |=> SPI_FAIL_SET && !MEAS_PATH_ENABLE) else $error("enable not refused");
   AST_GPIO_ERR: assert property (CFG_WR && CFG_SEL == 3'h1 && MEAS_PATH_ENABLE
      && CFG_WDATA[2:0] != GPIO_CONFIG |=> SPI_FAIL_SET) else $error("no error on pin config change");
   AST_SLEEP_FAIL: assert property (SLEEP_REQ && MEAS_PATH_ENABLE && !OTHER_WAKE_EN && !CFG_WR
      && (WAKE_CONTROL_ONE || GPIO_CONFIG == 3'h2) |=> SPI_FAIL_SET && RESTART_REQ && !SLEEP_GRANT)
      else $error("sleep not turned into restart");
   AST_KEEP: assert property (MEAS_PATH_ENABLE && !(CFG_WR && CFG_SEL == 3'h0)
      |=> MEAS_PATH_ENABLE) else $error("enable lost");
   AST_FS_WAKE: assert property (!MEAS_PATH_ENABLE && $past(MODE) == 3'h5 && $past(RESETN)
      |-> SENSE_WAKE_ACTIVE) else $error("no sense wake in fail-safe");

   cover property (MEAS_SWITCH_CLOSE);
   cover property (RESTART_REQ);
   cover property (SPI_FAIL_SET ##1 !SPI_FAIL_SET);
endmodule
`default_nettype wire

// ---- testbench/tb_hvmr_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_hvmr_ctrl;
   import hvmr_pkg::*;
   logic       CLK_SYS, RESETN, CFG_WR, SLEEP_REQ, OTHER_WAKE_EN, SENSE_IN, MULTI_IN, FAIL_ASSERT;
   logic       CLR_WAKE_ZERO, CLR_WAKE_ONE, MEAS_SWITCH_CLOSE, SENSE_PULL_UP_EN, SENSE_PULL_DN_EN;
   logic       MULTI_PULL_UP_EN, MULTI_PULL_DN_EN, FAIL_OUT_DRIVE, GPIO_LS_ON, GPIO_HS_ON, SENSE_INT;
   logic       MULTI_INT, SENSE_WAKE_ACTIVE, MULTI_WAKE_ACTIVE, WAKE_STATUS_ZERO, WAKE_STATUS_ONE;
   logic       SPI_FAIL_SET, RESTART_REQ, SLEEP_GRANT, MEAS_PATH_ENABLE, WAKE_CONTROL_ONE, req;
   logic       FAILOUT_FORCE_TEST;
   logic [1:0] WAKE_LEVEL_STATUS;
   logic [2:0] MODE, CFG_SEL, GPIO_CONFIG, rsel;
   logic [3:0] SENSE_PULL_CONFIG;
   logic [7:0] CFG_WDATA, rdata;
   logic [31:0] rnd;
   int         meas, gpio, pull, wctl, fot, n_errors, tests_run, cycles;

   hvmr_ctrl dut (.*);
   hvmr_host_model host (.clk(CLK_SYS), .req(req), .req_sel(rsel), .req_data(rdata),
      .cfg_wr(CFG_WR), .cfg_sel(CFG_SEL), .cfg_wdata(CFG_WDATA));

   initial begin
      CLK_SYS = 0;
      forever #25 CLK_SYS = ~CLK_SYS;
   end

   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic check_all(input logic fe);
      chk("error flag", SPI_FAIL_SET, fe);
      chk("enable", MEAS_PATH_ENABLE, meas);
      chk("pin cfg", GPIO_CONFIG, gpio);
      chk("pull cfg", SENSE_PULL_CONFIG, pull);
      chk("switch", MEAS_SWITCH_CLOSE, meas && MODE == 3'h1 && gpio != 1);
      chk("pulls", {MULTI_PULL_DN_EN, MULTI_PULL_UP_EN, SENSE_PULL_DN_EN, SENSE_PULL_UP_EN},
         meas ? 0 : pull);
      chk("low side", GPIO_LS_ON, !meas && gpio == 3);
      chk("high side", GPIO_HS_ON, !meas && gpio == 4);
      chk("fail drive", FAIL_OUT_DRIVE, !meas && gpio == 1 && (FAIL_ASSERT || fot || MODE == 3'h5));
      chk("sense int", SENSE_INT, meas ? 1'b0 : SENSE_IN);
      chk("multi int", MULTI_INT, meas ? 1'b0 : MULTI_IN);
      chk("sense wake", SENSE_WAKE_ACTIVE, !meas && (wctl || MODE == 3'h5));
      chk("multi wake", MULTI_WAKE_ACTIVE, !meas && gpio == 2);
      chk("wake cfg", WAKE_CONTROL_ONE, wctl);
      chk("force test", FAILOUT_FORCE_TEST, fot);
   endtask

   // The model decides the error before the write lands, as the device does.
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      logic fe;
      fe = 0;
      if (s == 3'h0) begin
         fe = d[0] && gpio != 0;
         if (!fe) meas = d[0];
      end
      if (s == 3'h1) begin
         fe = meas && d[2:0] != gpio;
         gpio = d[2:0];
      end
      if (s == 3'h2) pull = d[3:0];
      if (s == 3'h3) wctl = d[0];
      if (s == 3'h4) fot = d[0];
      req = 1;
      rsel = s;
      rdata = d;
      @(posedge CLK_SYS) #1;
      req = 0;
      @(posedge CLK_SYS) #1;
      check_all(fe);
   endtask

   task automatic sleep_cmd(input logic fe);
      SLEEP_REQ = 1;
      @(posedge CLK_SYS) #1;
      SLEEP_REQ = 0;
      chk("sleep error", SPI_FAIL_SET, fe);
      chk("restart", RESTART_REQ, fe);
      chk("grant", SLEEP_GRANT, !fe);
      // Let an edge pass so back-to-back commands never re-drive the strobe in one step.
      @(posedge CLK_SYS) #1;
   endtask

   task automatic settle();
      repeat (2) @(posedge CLK_SYS);
      #1;
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      MODE = 3'h1;
      RESETN = 0;
      req = 0;
      rsel = 3'h0;
      rdata = 8'h00;
      SLEEP_REQ = 0;
      OTHER_WAKE_EN = 0;
      SENSE_IN = 0;
      MULTI_IN = 0;
      FAIL_ASSERT = 0;
      CLR_WAKE_ZERO = 0;
      CLR_WAKE_ONE = 0;
      rnd = 32'h82B6;
      repeat (3) @(posedge CLK_SYS);
      #1 RESETN = 1;
      check_all(0);
      for (int g = 1; g < 5; g++) begin
         wr(3'h1, 8'(g));
         wr(3'h0, 8'h01);
      end
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h01);
      wr(3'h2, 8'h0F);
      wr(3'h1, 8'h03);
      wr(3'h1, 8'h03);
      wr(3'h1, 8'h00);
      FAIL_ASSERT = 1;
      for (int m = 0; m < 6; m++) begin
         MODE = 3'(m);
         settle();
         check_all(0);
      end
      wr(3'h0, 8'h00);
      chk("fail-safe wake", SENSE_WAKE_ACTIVE, 1);
      MODE = 3'h1;
      wr(3'h3, 8'h01);
      SENSE_IN = 1;
      settle();
      chk("level", WAKE_LEVEL_STATUS, 8'h01);
      chk("wake flag", WAKE_STATUS_ZERO, 1);
      CLR_WAKE_ZERO = 1;
      SENSE_IN = 0;
      @(posedge CLK_SYS) #1;
      CLR_WAKE_ZERO = 0;
      chk("cleared", WAKE_STATUS_ZERO, 0);
      wr(3'h1, 8'h02);
      MULTI_IN = 1;
      settle();
      chk("multi level", WAKE_LEVEL_STATUS, 8'h02);
      chk("multi flag", WAKE_STATUS_ONE, 1);
      CLR_WAKE_ONE = 1;
      MULTI_IN = 0;
      @(posedge CLK_SYS) #1;
      CLR_WAKE_ONE = 0;
      chk("multi cleared", WAKE_STATUS_ONE, 0);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h01);
      SENSE_IN = 1;
      MULTI_IN = 1;
      settle();
      chk("frozen level", WAKE_LEVEL_STATUS, 8'h00);
      chk("frozen flag", WAKE_STATUS_ZERO, 0);
      SENSE_IN = 0;
      MULTI_IN = 0;
      sleep_cmd(1);
      OTHER_WAKE_EN = 1;
      sleep_cmd(0);
      OTHER_WAKE_EN = 0;
      wr(3'h3, 8'h00);
      wr(3'h1, 8'h02);
      sleep_cmd(1);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h00);
      sleep_cmd(0);
      RESETN = 0;
      repeat (3) @(posedge CLK_SYS);
      #1 RESETN = 1;
      meas = 0;
      gpio = 0;
      pull = 0;
      wctl = 0;
      fot = 0;
      check_all(0);
      // Random writes against the model, pin codes kept legal.
      for (int i = 0; i < 60; i++) begin
         rnd = lfsr_next(rnd);
         wr(rnd[10:8], rnd[10:8] == 3'h1 ? 8'(rnd % 5) : rnd[7:0]);
      end
      print_verdict();
   end
endmodule

bind hvmr_ctrl hvmr_ctrl_checker checker_inst (.*);
`default_nettype wire
